// *** psm_top.sv ***
// power saving mode controller: slow-down, idle, power-down and wake-up
// How it works
// - slow-down divides cpu and peripheral clocks by 32
// - slow-down starts within two machine cycles
// - arm idle, then trigger plus slowdown together
// - interrupt leaves idle, slowdown stays set
// - mode 1 stops CPU, peripherals, oscillators
// - mode 1 holds pins, strobes driven low
// - mode 2 keeps RTC and LCD running
// - mode 3 keeps RTC only, LCD pins off
// - reset exit restores registers, vector zero
// - wake restarts oscillators, registers kept frozen
// - mode 1 wakes only from interrupt pin
// - modes 2, 3 wake source by select bit
// - arm write then trigger write enters power-down
// - arm and trigger self clear, read zero
// - without wake enable only reset exits
// - power-down right after trigger write
// - wake interrupt fetched from vector 007B
module psm_top #(
	parameter int unsigned MC_CLKS = psm_pkg::MC_CLKS
) (
	// system
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// wake and interrupt sources
	input  wire logic        ext_interrupt_zero,
	input  wire logic        rtc_irq,
	input  wire logic        osc_stable,
	input  wire logic        irq_pending,
	// cpu strobes in normal run
	input  wire logic        ale_cpu,
	input  wire logic        pss_cpu,
	// clock and power controls
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             rc_osc_en,
	output logic             main_osc_en,
	output logic             rtc_clk_en,
	output logic             lcd_clk_en,
	output logic             lcd_pins_off,
	output logic             port_hold,
	// pins and cpu events
	output logic             address_latch_strobe,
	output logic             program_store_strobe,
	output logic             wake_irq,
	output logic [15:0]      fetch_vector,
	output logic             slow_active
);
	localparam int unsigned CW = $clog2(psm_pkg::WAKE_LOW_CLKS + 1);
	localparam logic [CW-1:0] LOW_LAST = CW'(psm_pkg::WAKE_LOW_CLKS - 1);

	psm_clk_if ci ();

	psm_clkdiv #(
		.MC_CLKS (MC_CLKS)
	) u_div (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ci      (ci)
	);

	// pin synchronisers: pin, rtc and oscillator watchdog come from other domains
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	wire  [2:0] async_in = {osc_stable, rtc_irq, ext_interrupt_zero};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= async_in[g];
					sync2_reg[g] <= sync1_reg[g];
				end
			end
		end
	endgenerate
	wire pin_s = sync2_reg[0];
	wire rtc_s = sync2_reg[1];
	wire osc_s = sync2_reg[2];

	// bus front end: writes land in the data phase, reads take one wait state
	logic       wr_pend_reg;
	logic       rd_pend_reg;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;
	wire addr_ok = hsel & htrans[1] & hready;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok & hwrite;
			rd_pend_reg <= addr_ok & ~hwrite;
			if (addr_ok)
				addr_reg <= haddr[7:0];
		end
	end
	assign hreadyout = ~rd_pend_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	wire [7:0] wd      = hwdata[7:0];
	wire wr_pwr        = wr_pend_reg & (addr_reg == psm_pkg::PWR_OFS);
	wire wr_pwrx       = wr_pend_reg & (addr_reg == psm_pkg::PWRX_OFS);
	wire wr_lcd        = wr_pend_reg & (addr_reg == psm_pkg::LCD_OFS);
	wire wr_rtc        = wr_pend_reg & (addr_reg == psm_pkg::RTC_OFS);
	wire wr_sys        = wr_pend_reg & (addr_reg == psm_pkg::SYS_OFS);

	// software registers
	logic [7:0] pwr_reg;
	logic [7:0] pwrx_reg;
	logic [7:0] lcd_reg;
	logic [7:0] rtc_reg;
	logic [7:0] sys_reg;
	logic       pd_arm_reg;
	logic       idle_arm_reg;
	psm_pkg::psm_state_t state_reg;
	psm_pkg::psm_state_t state_next;

	// two-write sequence: the arm write must not carry the trigger, and vice versa
	wire pd_arm_wr   = wd[psm_pkg::B_PD_ARM] & ~wd[psm_pkg::B_PD_TRIG];
	wire pd_trig_wr  = wd[psm_pkg::B_PD_TRIG] & ~wd[psm_pkg::B_PD_ARM];
	wire id_arm_wr   = wd[psm_pkg::B_IDLE_ARM] & ~wd[psm_pkg::B_IDLE_TRIG];
	wire id_trig_wr  = wd[psm_pkg::B_IDLE_TRIG] & ~wd[psm_pkg::B_IDLE_ARM];
	wire in_run      = (state_reg == psm_pkg::ST_RUN);
	// immediate entry: the trigger write itself moves the state
	wire pd_go       = wr_pwr & in_run & pd_arm_reg & pd_trig_wr;
	// idle with slowdown: slowdown bit is stored by the same trigger write
	wire idle_go     = wr_pwr & in_run & idle_arm_reg & id_trig_wr & ~pd_go;
	// paged access: extension register only takes writes while page select is set
	wire pwrx_we     = wr_pwrx & sys_reg[psm_pkg::B_PAGE];

	// self clearing: arm and trigger bits are never stored in the register image
	localparam logic [7:0] PWR_KEEP = 8'h1C;
	always_ff @(posedge clk_sys) begin
		// reset state: every register returns to its reset value
		if (!rst_b) begin
			pwr_reg  <= psm_pkg::REG_RST;
			pwrx_reg <= psm_pkg::REG_RST;
			lcd_reg  <= psm_pkg::REG_RST;
			rtc_reg  <= psm_pkg::REG_RST;
			sys_reg  <= psm_pkg::REG_RST;
		end else begin
			if (wr_pwr)
				pwr_reg <= wd & PWR_KEEP;
			if (pwrx_we)
				pwrx_reg <= wd & 8'h90;
			if (wr_lcd)
				lcd_reg <= wd;
			if (wr_rtc)
				rtc_reg <= wd;
			if (wr_sys)
				sys_reg <= wd;
		end
	end

	// arm tracking: any other write to the control register drops the arm
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pd_arm_reg   <= 1'b0;
			idle_arm_reg <= 1'b0;
		end else if (wr_pwr) begin
			pd_arm_reg   <= pd_arm_wr;
			idle_arm_reg <= id_arm_wr;
		end
	end

	// power-down flavour taken from the lcd and rtc setup at entry
	wire rtc_on  = ~rtc_reg[psm_pkg::B_RTC_OFF];
	wire lcd_rtc = lcd_reg[psm_pkg::B_LCD_EN] & lcd_reg[psm_pkg::B_LCD_CLK] & rtc_on;
	// mode 1 setup: rtc shut down selects the deepest mode
	wire [1:0] mode_sel = ~rtc_on ? psm_pkg::PD_MODE1 :
		(lcd_rtc ? psm_pkg::PD_MODE2 : psm_pkg::PD_MODE3);

	logic [1:0]    pd_mode_reg;
	logic          wken_reg;
	logic          ws_reg;
	logic [CW-1:0] low_cnt_reg;
	wire in_pd   = (state_reg == psm_pkg::ST_PD);

	// low time: the pin must stay low this long before it counts as a request
	wire pin_wake = in_pd & ~pin_s & (low_cnt_reg == LOW_LAST);
	// mode 1 source: only the pin; source select for the other modes
	wire use_rtc  = (pd_mode_reg != psm_pkg::PD_MODE1) & ws_reg;
	// no wake: without the enable latched at entry only reset leaves
	wire wake_req = wken_reg & (use_rtc ? (in_pd & rtc_s) : pin_wake);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pd_mode_reg <= psm_pkg::PD_MODE1;
			wken_reg    <= 1'b0;
			ws_reg      <= 1'b0;
			low_cnt_reg <= '0;
		end else begin
			if (pd_go) begin
				pd_mode_reg <= mode_sel;
				wken_reg    <= pwrx_reg[psm_pkg::B_WKEN];
				ws_reg      <= pwrx_reg[psm_pkg::B_WSRC];
			end
			if (!in_pd || pin_s)
				low_cnt_reg <= '0;
			else if (low_cnt_reg != LOW_LAST)
				low_cnt_reg <= low_cnt_reg + 1'b1;
		end
	end

	// main state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			psm_pkg::ST_RUN: begin
				if (pd_go)
					state_next = psm_pkg::ST_PD;
				else if (idle_go)
					state_next = psm_pkg::ST_IDLE;
			end
			// idle exit: slowdown bit is left as software wrote it
			psm_pkg::ST_IDLE: begin
				if (irq_pending)
					state_next = psm_pkg::ST_RUN;
			end
			psm_pkg::ST_PD: begin
				if (wake_req)
					state_next = psm_pkg::ST_WAKE;
			end
			psm_pkg::ST_WAKE: begin
				if (osc_s)
					state_next = psm_pkg::ST_RUN;
			end
			default: state_next = psm_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			state_reg <= psm_pkg::ST_RUN;
		else
			state_reg <= state_next;
	end

	// divider control: oscillators stop only while fully powered down
	wire nx_run  = (state_next == psm_pkg::ST_RUN);
	wire nx_idle = (state_next == psm_pkg::ST_IDLE);
	wire nx_pd   = (state_next == psm_pkg::ST_PD);
	wire nx_down = nx_pd | (state_next == psm_pkg::ST_WAKE);
	wire [1:0] nx_mode = pd_go ? mode_sel : pd_mode_reg;
	assign ci.slow_req = pwr_reg[psm_pkg::B_SLOW];
	assign ci.osc_run  = ~in_pd;

	// lcd keeps its clock in power-down only in mode 2
	wire lcd_nx = lcd_reg[psm_pkg::B_LCD_EN] & ~(nx_down & (nx_mode != psm_pkg::PD_MODE2));
	wire wake_done = (state_reg == psm_pkg::ST_WAKE) & osc_s;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cpu_clk_en           <= 1'b0;
			periph_clk_en        <= 1'b0;
			rc_osc_en            <= 1'b1;
			main_osc_en          <= 1'b1;
			rtc_clk_en           <= 1'b1;
			lcd_clk_en           <= 1'b0;
			lcd_pins_off         <= 1'b1;
			port_hold            <= 1'b0;
			address_latch_strobe <= 1'b1;
			program_store_strobe <= 1'b1;
			wake_irq             <= 1'b0;
			fetch_vector         <= psm_pkg::VEC_RESET;
			slow_active          <= 1'b0;
		end else begin
			// divided enables: cpu and peripherals share the same tick
			cpu_clk_en    <= nx_run & ci.tick;
			periph_clk_en <= (nx_run | nx_idle) & ci.tick;
			// oscillators off; wake turns them back on
			rc_osc_en     <= ~nx_pd;
			main_osc_en   <= ~nx_pd;
			// rtc follows its own shutdown bit; lcd stops in mode 3
			rtc_clk_en    <= ~rtc_reg[psm_pkg::B_RTC_OFF];
			lcd_clk_en    <= lcd_nx;
			lcd_pins_off  <= ~lcd_nx;
			// pins frozen, strobes low while powered down
			port_hold     <= nx_down;
			address_latch_strobe <= nx_down ? 1'b0 : (nx_idle | ale_cpu);
			program_store_strobe <= nx_down ? 1'b0 : (nx_idle | pss_cpu);
			// wake interrupt: vector issued once the oscillator is stable
			wake_irq      <= wake_done;
			if (wake_done)
				fetch_vector <= psm_pkg::VEC_WAKE;
			slow_active   <= ci.slow_active;
		end
	end

	// read side: arm and trigger bits always read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_reg)
			psm_pkg::PWR_OFS:    rd_mux[7:0] = pwr_reg;
			psm_pkg::PWRX_OFS:   rd_mux[7:0] = pwrx_reg;
			psm_pkg::LCD_OFS:    rd_mux[7:0] = lcd_reg;
			psm_pkg::RTC_OFS:    rd_mux[7:0] = rtc_reg;
			psm_pkg::SYS_OFS:    rd_mux[7:0] = sys_reg;
			psm_pkg::STAT_OFS:   rd_mux[7:0] = {wken_reg, ci.slow_active, pd_mode_reg, state_reg};
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			hrdata_reg <= 32'h0000_0000;
		else if (rd_pend_reg)
			hrdata_reg <= rd_mux;
	end
endmodule : psm_top

// *** psm_pkg.sv ***
// constants, register map and state codes of the power saving mode controller
package psm_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] PWR_OFS    = 8'h00;
	localparam logic [7:0] PWRX_OFS   = 8'h04;
	localparam logic [7:0] LCD_OFS    = 8'h08;
	localparam logic [7:0] RTC_OFS    = 8'h0C;
	localparam logic [7:0] SYS_OFS    = 8'h10;
	localparam logic [7:0] STAT_OFS   = 8'h14;
	// power_control_reg fields
	localparam int unsigned B_IDLE_ARM  = 0;
	localparam int unsigned B_PD_ARM    = 1;
	localparam int unsigned B_GF0       = 2;
	localparam int unsigned B_GF1       = 3;
	localparam int unsigned B_SLOW      = 4;
	localparam int unsigned B_IDLE_TRIG = 5;
	localparam int unsigned B_PD_TRIG   = 6;
	// power_control_ext_reg fields
	localparam int unsigned B_WSRC      = 4;
	localparam int unsigned B_WKEN      = 7;
	// lcd_control_reg, rtc_control_reg, system_control_reg fields
	localparam int unsigned B_LCD_EN    = 0;
	localparam int unsigned B_LCD_CLK   = 1;
	localparam int unsigned B_RTC_OFF   = 3;
	localparam int unsigned B_PAGE      = 4;
	// reset values and wake vector
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [15:0] VEC_RESET   = 16'h0000;
	localparam logic [15:0] VEC_WAKE    = 16'h007B;
	// timing
	localparam int unsigned SLOW_DIV    = 32;
	localparam int unsigned MC_CLKS     = 12;
	localparam int unsigned CLK_MHZ     = 200;
	localparam int unsigned WAKE_LOW_NS = 10000;
	localparam int unsigned WAKE_LOW_CLKS = (WAKE_LOW_NS * CLK_MHZ + 999) / 1000;
	// power-down mode codes
	localparam logic [1:0] PD_MODE1 = 2'h1;
	localparam logic [1:0] PD_MODE2 = 2'h2;
	localparam logic [1:0] PD_MODE3 = 2'h3;
	typedef enum logic [3:0] {
		ST_RUN  = 4'h1,
		ST_IDLE = 4'h2,
		ST_PD   = 4'h4,
		ST_WAKE = 4'h8
	} psm_state_t;
endpackage : psm_pkg

// *** psm_clk_if.sv ***
// link between the controller and its slow-down clock divider
interface psm_clk_if;
	logic slow_req;
	logic osc_run;
	logic tick;
	logic slow_active;
	modport ctl (output slow_req, output osc_run, input tick, input slow_active);
	modport div (input slow_req, input osc_run, output tick, output slow_active);
endinterface : psm_clk_if

// *** psm_clkdiv.sv ***
// divide-by-32 clock enable with machine-cycle aligned mode switch
module psm_clkdiv #(
	parameter int unsigned MC_CLKS = psm_pkg::MC_CLKS
) (
	// system
	input wire logic clk_sys,
	input wire logic rst_b,
	// controller side
	psm_clk_if.div   ci
);
	localparam int unsigned MCW = $clog2(MC_CLKS);
	localparam logic [MCW-1:0] MC_LAST = MCW'(MC_CLKS - 1);
	localparam logic [4:0] DIV_LAST = 5'(psm_pkg::SLOW_DIV - 1);

	logic [MCW-1:0] mc_cnt_reg;
	logic [4:0]     div_cnt_reg;
	logic           slow_reg;
	wire            mc_edge = (mc_cnt_reg == MC_LAST);

	// switch at boundary: mode changes only at a machine-cycle edge, so never later than one
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mc_cnt_reg  <= '0;
			div_cnt_reg <= '0;
			slow_reg    <= 1'b0;
		end else if (ci.osc_run) begin
			mc_cnt_reg  <= mc_edge ? '0 : mc_cnt_reg + 1'b1;
			div_cnt_reg <= slow_reg ? div_cnt_reg + 1'b1 : '0;
			if (mc_edge)
				slow_reg <= ci.slow_req;
		end
	end

	// divide by 32: one enable in every 32 clocks while slowed
	assign ci.tick        = ci.osc_run & (~slow_reg | (div_cnt_reg == DIV_LAST));
	assign ci.slow_active = slow_reg;
endmodule : psm_clkdiv

// *** psm_properties.sv ***
// port-level assertions of the power saving mode controller
module psm_properties #(
	parameter int unsigned MC_CLKS = 12
) (
	// system
	input wire logic        clk_sys,
	input wire logic        rst_b,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	// clock and pin controls
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        rc_osc_en,
	input wire logic        main_osc_en,
	input wire logic        lcd_clk_en,
	input wire logic        lcd_pins_off,
	input wire logic        address_latch_strobe,
	input wire logic        program_store_strobe,
	input wire logic        wake_irq,
	input wire logic [15:0] fetch_vector,
	input wire logic        slow_active
);
	localparam int SD_MAX = 2 * MC_CLKS + 2;
	logic       ap_reg;
	logic       rp_reg;
	logic       arm_reg;
	logic       gv_reg;
	logic [4:0] gap_reg;
	wire        acc = hsel && htrans[1] && hreadyout && haddr[7:0] == 8'h00;
	wire        pcw = ap_reg && hreadyout;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ap_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			arm_reg <= 1'b0;
			gv_reg  <= 1'b0;
			gap_reg <= 5'h00;
		end else begin
			ap_reg  <= acc && hwrite;
			rp_reg  <= (acc && !hwrite) || (rp_reg && !hreadyout);
			arm_reg <= pcw ? (hwdata[1] && !hwdata[6]) : arm_reg;
			gv_reg  <= (periph_clk_en || gv_reg) && slow_active && main_osc_en;
			gap_reg <= periph_clk_en ? 5'h00 : gap_reg + 5'h01;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	slow_on_a: assert property (pcw && hwdata[4] && main_osc_en |-> ##[1:SD_MAX] slow_active)
		else $error("slow-down did not start in time");
	div_gap_a: assert property (gv_reg && gap_reg == 5'h1F && slow_active |-> periph_clk_en)
		else $error("slow clock enable later than 32 cycles");
	pd_both_a: assert property (pcw && hwdata[1] && hwdata[6] |=> main_osc_en [*3])
		else $error("arm and trigger together stopped the oscillator");
	pd_enter_a: assert property (arm_reg && pcw && hwdata[6] && !hwdata[1] |-> ##[1:2] !main_osc_en)
		else $error("power-down not entered after trigger");
	pd_stop_a: assert property (!main_osc_en |-> !rc_osc_en && !cpu_clk_en && !periph_clk_en)
		else $error("clock still running in power-down");
	pd_strobe_a: assert property (!main_osc_en |-> !address_latch_strobe && !program_store_strobe)
		else $error("strobes not low in power-down");
	lcd_pins_a: assert property (lcd_pins_off == !lcd_clk_en)
		else $error("lcd pins active with lcd stopped");
	rd_zero_a: assert property (rp_reg && hreadyout |-> !hrdata[1] && !hrdata[6])
		else $error("arm or trigger bit read as one");
	wake_vec_a: assert property (wake_irq |-> main_osc_en ##[0:1] fetch_vector == 16'h007B)
		else $error("wake interrupt without wake vector");
	rst_vec_a: assert property (rst_b && !$past(rst_b) |-> fetch_vector == 16'h0000 && main_osc_en)
		else $error("reset exit state wrong");
endmodule : psm_properties

bind psm_top psm_properties #(.MC_CLKS(MC_CLKS)) i_psm_properties (.clk_sys, .rst_b, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hreadyout, .hrdata, .cpu_clk_en, .periph_clk_en,
	.rc_osc_en, .main_osc_en, .lcd_clk_en, .lcd_pins_off, .address_latch_strobe,
	.program_store_strobe, .wake_irq, .fetch_vector, .slow_active);

// *** psm_far_model.sv ***
// far side: cpu strobes, wake pin, rtc interrupt and oscillator watchdog
module psm_far_model #(
	parameter int unsigned OSC_DLY = 20
) (
	// system
	input  wire logic clk_sys,
	input  wire logic main_osc_en,
	// bench commands
	input  wire logic pin_req,
	input  wire logic rtc_req,
	input  wire logic irq_req,
	// towards the controller
	output logic      ext_interrupt_zero,
	output logic      rtc_irq,
	output logic      osc_stable,
	output logic      irq_pending,
	output logic      ale_cpu,
	output logic      pss_cpu
);
	logic [7:0] osc_cnt = 8'h00;
	logic       tog     = 1'b0;
	// pin idles high, low only on request
	assign ext_interrupt_zero = !pin_req;
	assign rtc_irq            = rtc_req;
	assign irq_pending        = irq_req;
	assign ale_cpu            = tog;
	assign pss_cpu            = !tog;
	// stable only after a restart delay, so a design that skips the wait is seen
	assign osc_stable         = osc_cnt >= OSC_DLY;
	always @(posedge clk_sys) begin
		tog     <= !tog;
		osc_cnt <= !main_osc_en ? 8'h00 : (osc_stable ? osc_cnt : osc_cnt + 8'h01);
	end
endmodule : psm_far_model

// *** tb.sv ***
// self-checking bench of the power saving mode controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned MC = 4;
	logic        clk_sys = 1'b0;
	logic        rst_b   = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0;
	logic        pin_req = 1'b0;
	logic        rtc_req = 1'b0;
	logic        irq_req = 1'b0;
	logic        rdp     = 1'b0;
	logic [7:0]  g;
	logic [7:0]  exp_q[$];
	int          err_total = 0;
	int          n_checks  = 0;
	int          seed      = 62032;
	int          c1, c2;
	wire         hreadyout, hresp, ext_interrupt_zero, rtc_irq, osc_stable, irq_pending;
	wire         ale_cpu, pss_cpu, cpu_clk_en, periph_clk_en, rc_osc_en, main_osc_en;
	wire         rtc_clk_en, lcd_clk_en, lcd_pins_off, port_hold, wake_irq, slow_active;
	wire         address_latch_strobe, program_store_strobe;
	wire [31:0]  hrdata;
	wire [15:0]  fetch_vector;
	psm_far_model i_psm_far_model (.clk_sys, .main_osc_en, .pin_req, .rtc_req, .irq_req,
		.ext_interrupt_zero, .rtc_irq, .osc_stable, .irq_pending, .ale_cpu, .pss_cpu);
	psm_top #(.MC_CLKS(MC)) i_psm_top (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ext_interrupt_zero, .rtc_irq, .osc_stable, .irq_pending, .ale_cpu, .pss_cpu,
		.cpu_clk_en, .periph_clk_en, .rc_osc_en, .main_osc_en, .rtc_clk_en, .lcd_clk_en,
		.lcd_pins_off, .port_hold, .address_latch_strobe, .program_store_strobe, .wake_irq,
		.fetch_vector, .slow_active);
	initial forever #2.5 clk_sys = !clk_sys;
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tmo;
		err_total++;
		give_verdict();
	endtask : tmo
	// read results are compared against the oldest note
	always @(posedge clk_sys) begin
		if (rdp && hreadyout === 1'b1)
			chk(hrdata, {24'h0, exp_q.pop_front()});
		rdp <= (hsel && htrans[1] && !hwrite && hreadyout) || (rdp && !hreadyout);
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do begin
			@(posedge clk_sys);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do begin
			@(posedge clk_sys);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		hsel <= 1'b0;
		if (i >= 50)
			tmo();
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd
	// k: 0 oscillator off, 1 wake pulse, 2 slow on, 3 slow off
	task automatic wt(input int k);
		for (int i = 0; i < 6000; i++) begin
			@(posedge clk_sys);
			if (k == 0 && main_osc_en === 1'b0 || k == 1 && wake_irq === 1'b1
				|| k == 2 && slow_active === 1'b1 || k == 3 && slow_active === 1'b0)
				return;
		end
		tmo();
	endtask : wt
	task automatic rst(input int n);
		rst_b <= 1'b0;
		repeat (n) @(posedge clk_sys);
		rst_b <= 1'b1;
	endtask : rst
	task automatic pd;
		wr(psm_pkg::PWR_OFS, 8'h02);
		wr(psm_pkg::PWR_OFS, 8'h40);
		wt(0);
	endtask : pd
	// wake enable reached through page select
	task automatic wken(input logic [7:0] v);
		wr(psm_pkg::SYS_OFS, 8'h10);
		wr(psm_pkg::PWRX_OFS, v);
		wr(psm_pkg::SYS_OFS, 8'h00);
	endtask : wken
	task automatic hold(input logic p, input logic r);
		pin_req <= p;
		rtc_req <= r;
		repeat (2100) @(posedge clk_sys);
		pin_req <= 1'b0;
		rtc_req <= 1'b0;
	endtask : hold
	// power-down mode field resets to mode 1, so status reads 11h after reset
	initial begin
		rst(8);
		rd(psm_pkg::STAT_OFS, 8'h11);
		chk({16'h0, fetch_vector}, {16'h0, psm_pkg::VEC_RESET});
		chk(hresp, 1'b0);
		g = 8'($random(seed)) & 8'h0C;
		wr(psm_pkg::PWR_OFS, g | 8'h42);
		rd(psm_pkg::PWR_OFS, g);
		rd(psm_pkg::STAT_OFS, 8'h11);
		wr(psm_pkg::PWR_OFS, 8'h02);
		wr(psm_pkg::PWR_OFS, g);
		wr(psm_pkg::PWR_OFS, 8'h40);
		rd(psm_pkg::STAT_OFS, 8'h11);
		$display("entry sequence test done");
		wr(psm_pkg::PWR_OFS, 8'h10);
		wt(2);
		c1 = 0;
		c2 = 0;
		repeat (320) begin
			@(posedge clk_sys);
			c1 += periph_clk_en;
			c2 += cpu_clk_en;
		end
		chk(c1, 10);
		chk(c2, 10);
		rd(psm_pkg::STAT_OFS, 8'h51);
		wr(psm_pkg::PWR_OFS, 8'h00);
		wt(3);
		$display("slow-down test done");
		wr(psm_pkg::PWR_OFS, 8'h01);
		wr(psm_pkg::PWR_OFS, 8'h30);
		// the slow switch waits for a machine-cycle edge, so wait before reading
		wt(2);
		chk(cpu_clk_en, 1'b0);
		rd(psm_pkg::STAT_OFS, 8'h52);
		irq_req <= 1'b1;
		rd(psm_pkg::STAT_OFS, 8'h51);
		irq_req <= 1'b0;
		rd(psm_pkg::PWR_OFS, 8'h10);
		wr(psm_pkg::PWR_OFS, 8'h00);
		wt(3);
		$display("idle test done");
		wr(psm_pkg::PWRX_OFS, 8'h80);
		wr(psm_pkg::RTC_OFS, 8'h08);
		pd();
		chk(port_hold, 1'b1);
		chk(rtc_clk_en, 1'b0);
		rd(psm_pkg::STAT_OFS, 8'h14);
		hold(1'b1, 1'b0);
		rd(psm_pkg::STAT_OFS, 8'h14);
		rst(2 * MC);
		rd(psm_pkg::STAT_OFS, 8'h11);
		rd(psm_pkg::RTC_OFS, 8'h00);
		$display("mode 1 reset exit test done");
		wken(8'h90);
		wr(psm_pkg::LCD_OFS, 8'h03);
		pd();
		chk({lcd_clk_en, rtc_clk_en}, 2'h3);
		rd(psm_pkg::STAT_OFS, 8'hA4);
		hold(1'b1, 1'b0);
		rd(psm_pkg::STAT_OFS, 8'hA4);
		rtc_req <= 1'b1;
		wt(1);
		rtc_req <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({16'h0, fetch_vector}, {16'h0, psm_pkg::VEC_WAKE});
		chk(main_osc_en, 1'b1);
		rd(psm_pkg::LCD_OFS, 8'h03);
		$display("mode 2 wake test done");
		wr(psm_pkg::LCD_OFS, 8'h00);
		wken(8'h80);
		pd();
		chk({lcd_pins_off, lcd_clk_en}, 2'h2);
		hold(1'b0, 1'b1);
		rd(psm_pkg::STAT_OFS, 8'hB4);
		pin_req <= 1'b1;
		wt(1);
		pin_req <= 1'b0;
		$display("mode 3 wake test done");
		wr(psm_pkg::RTC_OFS, 8'h08);
		wken(8'h90);
		pd();
		hold(1'b0, 1'b1);
		rd(psm_pkg::STAT_OFS, 8'h94);
		pin_req <= 1'b1;
		wt(1);
		pin_req <= 1'b0;
		chk(main_osc_en, 1'b1);
		$display("mode 1 wake test done");
		give_verdict();
	end
endmodule : tb
